// >>> hdl/ccb_top.sv
// Charger control configuration bank with its field effects
`timescale 1ns/1ps
module ccb_top #(
  parameter logic [6:0] SMB_ADDR = ccb_pkg::SMB_ADDR_DEF,
  parameter logic [31:0] DB_C_CYCLES = ccb_pkg::DB_C_CYC,
  parameter logic [31:0] DB_D_CYCLES = ccb_pkg::DB_D_CYC,
  parameter logic [31:0] OTG_A_CYCLES = ccb_pkg::OTG_A_CYC,
  parameter logic [31:0] OTG_B_CYCLES = ccb_pkg::OTG_B_CYC,
  parameter logic [31:0] OTG_C_CYCLES = ccb_pkg::OTG_C_CYC,
  parameter logic [31:0] OTG_D_CYCLES = ccb_pkg::OTG_D_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic battery_absent_pin,
  input wire logic adapter_present,
  input wire logic vbat_below_min,
  input wire logic turbo_request,
  input wire logic comparator_raw,
  output logic comparator_out,
  output logic learn_active,
  output logic otg_active,
  output logic audio_filter_en,
  output logic [1:0] switch_freq_sel,
  output logic battery_fet_gate,
  output logic monitors_en,
  output logic monitor_sel_battery,
  output logic system_power_monitor_en,
  output logic system_output_en,
  output logic [1:0] low_system_voltage_alert_sel,
  output logic [1:0] trickle_current_sel
);
  import ccb_pkg::*;
  logic [7:0] cmd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr_stb;
  logic [15:0] ctl_one_q, ctl_two_q;
  logic ctl_three_q;
  logic [31:0] db_cnt_q, otg_cnt_q;
  logic otg_cmd_q, otg_pend_q;

  ccb_smbus_slave #(
    .ADDR(SMB_ADDR)
  ) u_smb (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .cmd(cmd),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rdata(rdata)
  );

  // Register decode and read mux
  wire hit_one = (cmd == CMD_CTL_ONE);
  wire hit_two = (cmd == CMD_CTL_TWO);
  wire hit_three = (cmd == CMD_CTL_THREE);
  wire [15:0] rd_three = {15'h0000, ctl_three_q};
  assign rdata = hit_one ? ctl_one_q :
                 hit_two ? ctl_two_q :
                 hit_three ? rd_three : 16'h0000;

  // Field views
  wire [1:0] db_sel = ctl_one_q[B_CMP_DB +: 2];
  wire exit_opt = ctl_one_q[B_EXIT];
  wire learn_en = ctl_one_q[B_LEARN];
  wire otg_en = ctl_one_q[B_OTG];
  wire turbo_on = ~ctl_one_q[B_TURBO_DIS];
  wire out_dis = ctl_one_q[B_OUT_DIS];
  wire [1:0] otg_sel = {ctl_two_q[B_OTG_DLY], ctl_three_q};

  wire [31:0] db_limit = (db_sel == 2'b00) ? DB_A_CYC :
                         (db_sel == 2'b01) ? DB_B_CYC :
                         (db_sel == 2'b10) ? DB_C_CYCLES : DB_D_CYCLES;
  wire [31:0] otg_limit = (otg_sel == 2'b00) ? OTG_A_CYCLES :
                          (otg_sel == 2'b01) ? OTG_B_CYCLES :
                          (otg_sel == 2'b10) ? OTG_C_CYCLES : OTG_D_CYCLES;

  // Learn mode needs a battery, and may be dropped below minimum voltage
  wire learn_d = learn_en & ~battery_absent_pin & ~(exit_opt & vbat_below_min);
  // Turbo or a disabled output both force the battery FET gate on
  wire gate_d = out_dis | (turbo_on & turbo_request);
  wire mon_d = adapter_present | ~ctl_one_q[B_MON_DIS];
  wire db_done = (db_cnt_q >= db_limit - 32'h1);
  wire otg_rise = otg_en & ~otg_cmd_q;
  wire otg_done = otg_pend_q & (otg_cnt_q >= otg_limit - 32'h1);

  // Register writes; bit 7 and unheld bits stay zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctl_one_q <= CTL_ONE_RST;
      ctl_two_q <= CTL_TWO_RST;
      ctl_three_q <= 1'b0;
    end else if (wr_stb) begin
      if (hit_one) begin
        ctl_one_q <= wdata & CTL_ONE_WMASK;
      end
      if (hit_two) begin
        ctl_two_q <= wdata & CTL_TWO_WMASK;
      end
      if (hit_three) begin
        ctl_three_q <= wdata[B_OTG_DLY3];
      end
    end
  end

  // Comparator assertion debounce; release is immediate
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      db_cnt_q <= 32'h0;
      comparator_out <= 1'b0;
    end else if (!comparator_raw) begin
      db_cnt_q <= 32'h0;
      comparator_out <= 1'b0;
    end else if (!comparator_out) begin
      db_cnt_q <= db_cnt_q + 32'h1;
      comparator_out <= db_done;
    end
  end

  // OTG start-up delay counted from the enable command
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      otg_cmd_q <= 1'b0;
      otg_pend_q <= 1'b0;
      otg_cnt_q <= 32'h0;
      otg_active <= 1'b0;
    end else begin
      otg_cmd_q <= otg_en;
      if (!otg_en) begin
        otg_pend_q <= 1'b0;
        otg_active <= 1'b0;
      end else if (otg_rise) begin
        otg_pend_q <= 1'b1;
        otg_cnt_q <= 32'h0;
      end else if (otg_done) begin
        otg_pend_q <= 1'b0;
        otg_active <= 1'b1;
      end else if (otg_pend_q) begin
        otg_cnt_q <= otg_cnt_q + 32'h1;
      end
    end
  end

  // Registered field outputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      learn_active <= 1'b0;
      audio_filter_en <= 1'b0;
      switch_freq_sel <= CTL_ONE_RST[B_FREQ +: 2];
      battery_fet_gate <= 1'b0;
      monitors_en <= 1'b1;
      monitor_sel_battery <= 1'b0;
      system_power_monitor_en <= 1'b0;
      system_output_en <= 1'b1;
      low_system_voltage_alert_sel <= 2'b00;
      trickle_current_sel <= 2'b00;
    end else begin
      learn_active <= learn_d;
      audio_filter_en <= ctl_one_q[B_AUDIO];
      switch_freq_sel <= ctl_one_q[B_FREQ +: 2];
      battery_fet_gate <= gate_d;
      monitors_en <= mon_d;
      monitor_sel_battery <= ctl_one_q[B_MON_SEL];
      system_power_monitor_en <= ctl_one_q[B_SYSTEM_POWER_MONITOR];
      system_output_en <= ~out_dis;
      low_system_voltage_alert_sel <= ctl_one_q[B_LOWSYS +: 2];
      trickle_current_sel <= ctl_two_q[B_TRICKLE +: 2];
    end
  end
endmodule

// >>> hdl/ccb_pkg.sv
// Constants for the charger control configuration bank
// Operation
// - Bits 15:14 pick comparator assertion debounce time
// - Exit option clear keeps learn below minimum
// - Bit 12 enables battery learn, reset off
// - Learn only while battery absent input low
// - Bit 11 enables reverse OTG output, reset off
// - Bit 10 enables audio filter, reset off
// - Bits 9:8 select switching frequency, default 732kHz
// - Bit 6 low enables turbo, gate driven
// - Bit 5 gates monitors only without adapter
// - Bit 4 picks adapter or battery monitor
// - Bit 3 enables system power monitor
// - Bit 2 disables output, stops switching, gate on
// - Bits 1:0 set low system voltage alert
// - Second register 15:14 sets trickle current
// - Two bits jointly choose OTG start delay
package ccb_pkg;
  localparam logic [7:0] CMD_CTL_ONE = 8'h3C;
  localparam logic [7:0] CMD_CTL_TWO = 8'h3D;
  localparam logic [7:0] CMD_CTL_THREE = 8'h4C;
  localparam logic [15:0] CTL_ONE_RST = 16'h0200;
  localparam logic [15:0] CTL_ONE_WMASK = 16'hFF7F;
  localparam logic [15:0] CTL_TWO_RST = 16'h0000;
  localparam logic [15:0] CTL_TWO_WMASK = 16'hE000;
  localparam logic [15:0] CTL_THREE_WMASK = 16'h0001;
  localparam logic [6:0] SMB_ADDR_DEF = 7'h09;
  localparam int B_CMP_DB = 14;
  localparam int B_EXIT = 13;
  localparam int B_LEARN = 12;
  localparam int B_OTG = 11;
  localparam int B_AUDIO = 10;
  localparam int B_FREQ = 8;
  localparam int B_TURBO_DIS = 6;
  localparam int B_MON_DIS = 5;
  localparam int B_MON_SEL = 4;
  localparam int B_SYSTEM_POWER_MONITOR = 3;
  localparam int B_OUT_DIS = 2;
  localparam int B_LOWSYS = 0;
  localparam int B_TRICKLE = 14;
  localparam int B_OTG_DLY = 13;
  localparam int B_OTG_DLY3 = 0;
  localparam longint CLK_PERIOD_NS = 50;
  localparam longint DB_A_NS = 2000;
  localparam longint DB_B_NS = 12000;
  localparam longint DB_C_NS = 2000000;
  localparam longint DB_D_NS = 5000000000;
  localparam longint OTG_A_NS = 1300000000;
  localparam longint OTG_B_NS = 1350000000;
  localparam longint OTG_C_NS = 150000000;
  localparam longint OTG_D_NS = 7500000;
  localparam logic [31:0] DB_A_CYC = 32'((DB_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] DB_B_CYC = 32'((DB_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] DB_C_CYC = 32'((DB_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] DB_D_CYC = 32'((DB_D_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] OTG_A_CYC = 32'((OTG_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] OTG_B_CYC = 32'((OTG_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] OTG_C_CYC = 32'((OTG_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] OTG_D_CYC = 32'((OTG_D_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum {SMB_IDLE, SMB_RX, SMB_ACK, SMB_TX, SMB_RACK} ccb_smb_state_t;
endpackage

// >>> hdl/ccb_smbus_slave.sv
// Serial management bus word slave for the configuration bank
`timescale 1ns/1ps
module ccb_smbus_slave #(
  parameter logic [6:0] ADDR = ccb_pkg::SMB_ADDR_DEF
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] cmd,
  output logic [15:0] wdata,
  output logic wr_stb,
  input wire logic [15:0] rdata
);
  import ccb_pkg::*;
  ccb_smb_state_t st_q;
  logic scl_q, sda_q, rw_q, ack_q, hi_q;
  logic [7:0] sh_q, lo_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  wire rise = scl_in & ~scl_q;
  wire fall = ~scl_in & scl_q;
  wire start = scl_in & scl_q & sda_q & ~sda_in;
  wire stop = scl_in & scl_q & ~sda_q & sda_in;
  wire full = (bit_q == 4'h8);
  wire addr_hit = (sh_q[7:1] == ADDR);
  wire [7:0] tx_byte = hi_q ? rdata[15:8] : rdata[7:0];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q <= SMB_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      hi_q <= 1'b0;
      sh_q <= 8'h00;
      lo_q <= 8'h00;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      cmd <= 8'h00;
      wdata <= 16'h0000;
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      wr_stb <= 1'b0;
      if (start) begin
        st_q <= SMB_RX;
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        sda_oe_n <= 1'b1;
      end else if (stop) begin
        st_q <= SMB_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (st_q)
          SMB_RX: begin
            if (rise && !full) begin
              sh_q <= {sh_q[6:0], sda_in};
              bit_q <= bit_q + 4'h1;
            end else if (fall && full) begin
              bit_q <= 4'h0;
              st_q <= SMB_ACK;
              sda_oe_n <= 1'b0;
              case (byte_q)
                2'h0: begin
                  rw_q <= sh_q[0];
                  hi_q <= 1'b0;
                  if (!addr_hit) begin
                    st_q <= SMB_IDLE;
                    sda_oe_n <= 1'b1;
                  end
                end
                2'h1: cmd <= sh_q;
                2'h2: lo_q <= sh_q;
                default: begin
                  wdata <= {sh_q, lo_q};
                  wr_stb <= 1'b1;
                end
              endcase
              if (byte_q != 2'h3) begin
                byte_q <= byte_q + 2'h1;
              end
            end
          end
          SMB_ACK: begin
            if (fall) begin
              if (rw_q) begin
                st_q <= SMB_TX;
                sh_q <= {tx_byte[6:0], 1'b0};
                sda_oe_n <= tx_byte[7];
                bit_q <= 4'h1;
              end else begin
                st_q <= SMB_RX;
                sda_oe_n <= 1'b1;
              end
            end
          end
          SMB_TX: begin
            if (fall) begin
              if (full) begin
                st_q <= SMB_RACK;
                sda_oe_n <= 1'b1;
              end else begin
                sda_oe_n <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          SMB_RACK: begin
            if (rise) begin
              ack_q <= ~sda_in;
            end else if (fall) begin
              if (ack_q) begin
                // Bytes after the high byte repeat it rather than wrap
                hi_q <= 1'b1;
                st_q <= SMB_TX;
                sh_q <= {rdata[14:8], 1'b0};
                sda_oe_n <= rdata[15];
                bit_q <= 4'h1;
              end else begin
                st_q <= SMB_IDLE;
              end
            end
          end
          default: st_q <= SMB_IDLE;
        endcase
      end
    end
  end
endmodule

// >>> verif/ccb_host_model.sv
// Bus master model standing in for the host controller
`timescale 1ns/1ps
module ccb_host_model (
  input wire logic core_clk,
  output logic scl_in,
  output logic sda_in,
  input wire logic sda_oe_n
);
  logic sdo_q = 1'b1;
  // Pulled-up wire; sda_out is always low, so the enable alone decides
  assign sda_in = sdo_q & (sda_oe_n !== 1'b0);
  initial scl_in = 1'b1;
  task automatic ph(input logic d, input logic c);
    sdo_q <= d;
    scl_in <= c;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic bt(input logic b, output logic r);
    ph(b, 1'b0);
    ph(b, 1'b1);
    r = sda_in;
  endtask
  task automatic by(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], r[i]);
    end
    bt(a, k);
  endtask
  task automatic st();
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
    ph(1'b0, 1'b0);
  endtask
  task automatic sp();
    ph(1'b0, 1'b0);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
    output logic ok);
    logic [7:0] r;
    logic [3:0] k;
    st();
    by({a, 1'b0}, 1'b1, r, k[0]);
    by(c, 1'b1, r, k[1]);
    by(d[7:0], 1'b1, r, k[2]);
    by(d[15:8], 1'b1, r, k[3]);
    sp();
    ok = (k == 4'h0);
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic [7:0] r;
    logic k;
    st();
    by({ccb_pkg::SMB_ADDR_DEF, 1'b0}, 1'b1, r, k);
    by(c, 1'b1, r, k);
    st();
    by({ccb_pkg::SMB_ADDR_DEF, 1'b1}, 1'b1, r, k);
    by(8'hFF, 1'b0, v[7:0], k);
    by(8'hFF, 1'b1, v[15:8], k);
    sp();
  endtask
endmodule

// >>> verif/ccb_checker.sv
// Port-level assertions for the charger control configuration bank
`timescale 1ns/1ps
module ccb_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sda_oe_n,
  input wire logic battery_absent_pin,
  input wire logic adapter_present,
  input wire logic turbo_request,
  input wire logic comparator_raw,
  input wire logic comparator_out,
  input wire logic learn_active,
  input wire logic otg_active,
  input wire logic [1:0] switch_freq_sel,
  input wire logic battery_fet_gate,
  input wire logic monitors_en,
  input wire logic system_output_en
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  AST_RST_DEFAULTS: assert property (disable iff (1'b0) !nrst |=> sda_oe_n
    && !learn_active && !otg_active && switch_freq_sel == 2'h2 && system_output_en && monitors_en)
    else $error("outputs not at defaults after reset");
  AST_CMP_RELEASE: assert property (!comparator_raw |=> !comparator_out)
    else $error("comparator held after raw release");
  AST_CMP_DEBOUNCE: assert property ($rose(comparator_out) |-> $past(comparator_raw, 38))
    else $error("comparator asserted before debounce");
  AST_LEARN_BATT: assert property ($past(battery_absent_pin) |-> !learn_active)
    else $error("learn active without battery");
  AST_MON_AUTO: assert property (adapter_present |=> monitors_en)
    else $error("monitors off with adapter present");
  AST_GATE_OUT_DIS: assert property (!system_output_en |-> battery_fet_gate)
    else $error("gate off while output disabled");
  AST_GATE_IDLE: assert property (system_output_en && !$past(turbo_request)
    |-> !battery_fet_gate) else $error("gate on without cause");
  AST_OTG_DELAY: assert property ($rose(otg_active) |-> !$past(otg_active, 60))
    else $error("reverse output started without delay");
  CV_LEARN: cover property (learn_active);
  CV_OTG: cover property ($rose(otg_active));
  CV_CMP: cover property ($rose(comparator_out));
endmodule
bind ccb_top ccb_checker chk_i (.core_clk, .nrst, .sda_oe_n, .battery_absent_pin,
  .adapter_present, .turbo_request, .comparator_raw, .comparator_out, .learn_active,
  .otg_active, .switch_freq_sel, .battery_fet_gate, .monitors_en, .system_output_en);

// >>> verif/charger_control_config_bank_tb.sv
// Self-checking bench for the charger control configuration bank
`timescale 1ns/1ps
module charger_control_config_bank_tb;
  import ccb_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic battery_absent_pin = 1'b0;
  logic adapter_present = 1'b0;
  logic vbat_below_min = 1'b0;
  logic turbo_request = 1'b0;
  logic comparator_raw = 1'b0;
  logic scl_in, sda_in, sda_out, sda_oe_n, comparator_out, learn_active, otg_active, ok;
  logic audio_filter_en, battery_fet_gate, monitors_en, monitor_sel_battery;
  logic system_power_monitor_en, system_output_en;
  logic [1:0] switch_freq_sel, low_system_voltage_alert_sel, trickle_current_sel;
  logic [7:0] flg;
  logic [15:0] v;
  int bad_count = 0;
  int check_count = 0;
  int n;
  int dbn[4] = '{40, 240, int'(DB_C_CYC), 60};
  int otn[4] = '{70, 80, 90, 100};
  assign flg = {audio_filter_en, monitor_sel_battery, system_power_monitor_en,
    system_output_en, monitors_en, learn_active, otg_active, battery_fet_gate};
  initial forever #25 core_clk = ~core_clk;
  // Longest counts shortened; the 2 ms debounce keeps its real length
  ccb_top #(.DB_D_CYCLES(32'h3C), .OTG_A_CYCLES(32'h46),
    .OTG_B_CYCLES(32'h50), .OTG_C_CYCLES(32'h5A), .OTG_D_CYCLES(32'h64)) dut (
    .core_clk, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe_n, .battery_absent_pin,
    .adapter_present, .vbat_below_min, .turbo_request, .comparator_raw, .comparator_out,
    .learn_active, .otg_active, .audio_filter_en, .switch_freq_sel, .battery_fet_gate,
    .monitors_en, .monitor_sel_battery, .system_power_monitor_en, .system_output_en,
    .low_system_voltage_alert_sel, .trickle_current_sel);
  ccb_host_model host (.core_clk, .scl_in, .sda_in, .sda_oe_n);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic wreg(input logic [7:0] c, input logic [15:0] d);
    host.wr(SMB_ADDR_DEF, c, d, ok);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    host.rd(c, v);
    chk(v, e);
  endtask
  initial begin
    cy(10);
    nrst <= 1'b1;
    cy(2);
    chk(16'(flg), 16'h0018);
    chk(16'(switch_freq_sel), 16'h0002);
    rchk(CMD_CTL_ONE, 16'h0200);
    rchk(CMD_CTL_TWO, 16'h0000);
    wreg(CMD_CTL_ONE, 16'hFFFF);
    chk(16'(flg), 16'h00E5);
    rchk(CMD_CTL_ONE, 16'hFF7F);
    adapter_present <= 1'b1;
    cy(3);
    chk(16'(monitors_en), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wreg(CMD_CTL_ONE, 16'(i) * 16'h0101);
      wreg(CMD_CTL_TWO, 16'(i) << 14);
      chk({switch_freq_sel, low_system_voltage_alert_sel, trickle_current_sel},
        16'(i) * 16'h0015);
    end
    wreg(CMD_CTL_ONE, 16'h1200);
    chk(16'(learn_active), 16'h0001);
    vbat_below_min <= 1'b1;
    cy(3);
    chk(16'(learn_active), 16'h0001);
    wreg(CMD_CTL_ONE, 16'h3200);
    chk(16'(learn_active), 16'h0000);
    vbat_below_min <= 1'b0;
    cy(3);
    chk(16'(learn_active), 16'h0001);
    battery_absent_pin <= 1'b1;
    cy(3);
    chk(16'(learn_active), 16'h0000);
    battery_absent_pin <= 1'b0;
    turbo_request <= 1'b1;
    wreg(CMD_CTL_ONE, 16'h0200);
    chk(16'(battery_fet_gate), 16'h0001);
    wreg(CMD_CTL_ONE, 16'h0240);
    chk(16'(battery_fet_gate), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wreg(CMD_CTL_ONE, 16'(i) * 16'h4000 + 16'h0240);
      comparator_raw <= 1'b1;
      n = 0;
      while (comparator_out !== 1'b1 && n < 45000) begin
        cy(1);
        n++;
      end
      chk(16'(n >= dbn[i] && n <= dbn[i] + 4), 16'h0001);
      comparator_raw <= 1'b0;
      cy(2);
      chk(16'(comparator_out), 16'h0000);
    end
    for (int i = 0; i < 4; i++) begin
      wreg(CMD_CTL_TWO, 16'(i / 2) << 13);
      wreg(CMD_CTL_THREE, 16'(i % 2));
      wreg(CMD_CTL_ONE, 16'h0A00);
      n = 0;
      while (otg_active !== 1'b1 && n < 400) begin
        cy(1);
        n++;
      end
      // Count starts at commit, about twenty cycles before the write returns
      chk(16'(n >= otn[i] - 26 && n <= otn[i] - 15), 16'h0001);
      wreg(CMD_CTL_ONE, 16'h0200);
      chk(16'(otg_active), 16'h0000);
    end
    host.wr(7'h0A, CMD_CTL_ONE, 16'h0000, ok);
    chk(16'(ok), 16'h0000);
    rchk(CMD_CTL_ONE, 16'h0200);
    rchk(8'h50, 16'h0000);
    wreg(CMD_CTL_ONE, 16'hFFFF);
    nrst <= 1'b0;
    cy(3);
    nrst <= 1'b1;
    cy(2);
    chk(16'(flg), 16'h0019);
    rchk(CMD_CTL_ONE, 16'h0200);
    complete_run();
  end
  initial begin
    cy(90000);
    bad_count++;
    complete_run();
  end
endmodule
